// ==== src/tmw_top.sv ====
/*
  tmw_top: 8-bit timer with channel-B waveform unit, wave mode decode, channel-B force strobe and tick source select.
  Assumes a single-cycle register port on ref_clk_in; port direction, port data and vector acknowledge come
  from logic on the same clock; the external count pin is asynchronous.
*/
`timescale 1ns/1ns
`default_nettype none

module tmw_top
  import tmw_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       resetn_in,
  input  wire logic       clk_en_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output var  logic [7:0] rdata_out,
  input  wire logic       ext_count_pin_in,
  input  wire logic       port_b_dir_in,
  input  wire logic       port_b_data_in,
  input  wire logic       match_b_ack_in,
  output var  logic       pin_b_out,
  output var  logic       pin_b_oe_out,
  output var  logic       wave_b_connected_out,
  output var  logic [7:0] count_out,
  output var  logic       wrap_flag_out,
  output var  logic       match_a_flag_out,
  output var  logic       match_b_flag_out
);

  logic       rst_s1_reg;
  logic       rst_s2_reg;
  logic       rst_n;
  logic [1:0] chan_a_action_reg;
  logic [1:0] chan_b_action_reg;
  logic [1:0] wgm_lo_reg;
  logic       wgm2_reg;
  logic [2:0] tick_source_sel_reg;
  logic [7:0] count_reg;
  logic       down_reg;
  logic       block_reg;
  logic [7:0] cmp_a_buf_reg;
  logic [7:0] cmp_b_buf_reg;
  logic [7:0] cmp_a_act_reg;
  logic [7:0] cmp_b_act_reg;
  logic [2:0] flags_reg;
  logic       wave_b_reg;
  logic [9:0] pre_reg;
  logic       ext_s1_reg;
  logic       ext_s2_reg;
  logic       ext_s3_reg;
  logic [2:0] wave_mode_sel;
  logic       pwm;
  logic       phase;
  logic       fast;
  logic       top_from_a;
  logic [7:0] top_val;
  logic       at_top;
  logic       tick;
  logic       ext_rise;
  logic       ext_fall;
  logic       wr_ctrl_a;
  logic       wr_ctrl_b;
  logic       wr_flags;
  logic       cnt_wr;
  logic       step;
  logic       upd_ev;
  logic       match_a_ev;
  logic       match_b_ev;
  logic       wrap_ev;
  logic       force_b;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  // reset release
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  assign wr_ctrl_a = wr_in && (addr_in == TMW_ADDR_CTRL_A);
  assign wr_ctrl_b = wr_in && (addr_in == TMW_ADDR_CTRL_B);
  assign wr_flags  = wr_in && (addr_in == TMW_ADDR_FLAGS);
  assign cnt_wr    = wr_in && (addr_in == TMW_ADDR_COUNT);

  // mode decode
  assign wave_mode_sel = {wgm2_reg, wgm_lo_reg};
  assign pwm           = wave_mode_sel[0];
  assign phase         = (wave_mode_sel[1:0] == TMW_WM_PHASE[1:0]);
  assign fast          = (wave_mode_sel[1:0] == TMW_WM_FAST[1:0]);
  assign top_from_a    = (wave_mode_sel == TMW_WM_CTC) || (wave_mode_sel == TMW_WM_PHASE_A) ||
                         (wave_mode_sel == TMW_WM_FAST_A);
  assign top_val       = top_from_a ? cmp_a_act_reg : TMW_MAX;
  assign at_top        = (count_reg == top_val);

  // control registers; reserved modes 4 and 6 run as plain counters
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      chan_a_action_reg   <= TMW_ACT_OFF;
      chan_b_action_reg   <= TMW_ACT_OFF;
      wgm_lo_reg          <= 2'h0;
      wgm2_reg            <= 1'b0;
      tick_source_sel_reg <= TMW_CS_STOP;
    end else if (clk_en_in) begin
      if (wr_ctrl_a) begin
        chan_a_action_reg <= wdata_in[TMW_ACT_A_LSB +: 2];
        chan_b_action_reg <= wdata_in[TMW_ACT_B_LSB +: 2];
        wgm_lo_reg        <= wdata_in[TMW_WGM_LO_LSB +: 2];
      end
      if (wr_ctrl_b) begin
        wgm2_reg            <= wdata_in[TMW_WGM2_BIT];
        tick_source_sel_reg <= wdata_in[TMW_CS_LSB +: 3];
      end
    end
  end

  // count pin synchroniser and edge detect
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else if (clk_en_in) begin
      ext_s1_reg <= ext_count_pin_in;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end
  assign ext_rise = ext_s2_reg && !ext_s3_reg;
  assign ext_fall = !ext_s2_reg && ext_s3_reg;

  // prescaler runs only while a source is selected, so a stopped timer draws no toggling
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= 10'h000;
    end else if (clk_en_in) begin
      if (tick_source_sel_reg == TMW_CS_STOP) begin
        pre_reg <= 10'h000;
      end else begin
        pre_reg <= pre_reg + 10'h001;
      end
    end
  end

  always_comb begin
    tick = 1'b0;
    unique case (tick_source_sel_reg)
      TMW_CS_STOP:     tick = 1'b0;
      TMW_CS_DIV1:     tick = 1'b1;
      TMW_CS_DIV8:     tick = ((pre_reg & TMW_MASK_DIV8) == TMW_MASK_DIV8);
      TMW_CS_DIV64:    tick = ((pre_reg & TMW_MASK_DIV64) == TMW_MASK_DIV64);
      TMW_CS_DIV256:   tick = ((pre_reg & TMW_MASK_DIV256) == TMW_MASK_DIV256);
      TMW_CS_DIV1024:  tick = (pre_reg == TMW_MASK_DIV1024);
      TMW_CS_EXT_FALL: tick = ext_fall;
      TMW_CS_EXT_RISE: tick = ext_rise;
    endcase
  end

  assign step       = tick && !cnt_wr;
  assign upd_ev     = step && at_top && !down_reg;
  assign match_a_ev = step && !block_reg && (count_reg == cmp_a_act_reg);
  assign match_b_ev = step && !block_reg && (count_reg == cmp_b_act_reg);
  assign force_b    = wr_ctrl_b && wdata_in[TMW_FOC_B_BIT] && !pwm;

  always_comb begin
    wrap_ev = 1'b0;
    if (phase) begin
      wrap_ev = step && down_reg && (count_reg == TMW_BOTTOM);
    end else if (wave_mode_sel == TMW_WM_FAST_A) begin
      wrap_ev = step && at_top;
    end else begin
      wrap_ev = step && (count_reg == TMW_MAX);
    end
  end

  // counter and direction; a write wins over a tick in the same cycle
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= TMW_REG_RESET;
      down_reg  <= 1'b0;
    end else if (clk_en_in) begin
      if (cnt_wr) begin
        count_reg <= wdata_in;
      end else if (step) begin
        if (phase) begin
          if (!down_reg && at_top) begin
            down_reg  <= 1'b1;
            count_reg <= count_reg - 8'h01;
          end else if (down_reg && (count_reg == TMW_BOTTOM)) begin
            down_reg  <= 1'b0;
            count_reg <= count_reg + 8'h01;
          end else if (down_reg) begin
            count_reg <= count_reg - 8'h01;
          end else begin
            count_reg <= count_reg + 8'h01;
          end
        end else if ((fast || (wave_mode_sel == TMW_WM_CTC)) && at_top) begin
          count_reg <= TMW_BOTTOM;
        end else begin
          count_reg <= count_reg + 8'h01;
        end
      end
      if (!phase) begin
        down_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      block_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (cnt_wr) begin
        block_reg <= 1'b1;
      end else if (tick) begin
        block_reg <= 1'b0;
      end
    end
  end

  // compare buffers and active values
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cmp_a_buf_reg <= TMW_REG_RESET;
      cmp_b_buf_reg <= TMW_REG_RESET;
      cmp_a_act_reg <= TMW_REG_RESET;
      cmp_b_act_reg <= TMW_REG_RESET;
    end else if (clk_en_in) begin
      if (wr_in && (addr_in == TMW_ADDR_CMP_A)) begin
        cmp_a_buf_reg <= wdata_in;
      end
      if (wr_in && (addr_in == TMW_ADDR_CMP_B)) begin
        cmp_b_buf_reg <= wdata_in;
      end
      if (!pwm) begin
        cmp_a_act_reg <= (wr_in && (addr_in == TMW_ADDR_CMP_A)) ? wdata_in : cmp_a_buf_reg;
        cmp_b_act_reg <= (wr_in && (addr_in == TMW_ADDR_CMP_B)) ? wdata_in : cmp_b_buf_reg;
      end else if (upd_ev) begin
        cmp_a_act_reg <= cmp_a_buf_reg;
        cmp_b_act_reg <= cmp_b_buf_reg;
      end
    end
  end

  // flags: a set in the cycle of a clear wins
  assign flag_set = {match_b_ev, match_a_ev, wrap_ev};
  assign flag_clr = {(wr_flags && wdata_in[TMW_FLAG_MATCH_B]) || match_b_ack_in,
                     wr_flags && wdata_in[TMW_FLAG_MATCH_A],
                     wr_flags && wdata_in[TMW_FLAG_WRAP]};
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= 3'h0;
    end else if (clk_en_in) begin
      flags_reg <= flag_set | (flags_reg & ~flag_clr);
    end
  end

  // channel-B waveform unit
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wave_b_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (!pwm) begin
        if (match_b_ev || force_b) begin
          unique case (chan_b_action_reg)
            TMW_ACT_OFF:    wave_b_reg <= wave_b_reg;
            TMW_ACT_TOGGLE: wave_b_reg <= !wave_b_reg;
            TMW_ACT_CLEAR:  wave_b_reg <= 1'b0;
            TMW_ACT_SET:    wave_b_reg <= 1'b1;
          endcase
        end
      end else if (fast && chan_b_action_reg[1]) begin
        if (match_b_ev && (cmp_b_act_reg != top_val)) begin
          wave_b_reg <= chan_b_action_reg[0];
        end else if (upd_ev) begin
          wave_b_reg <= !chan_b_action_reg[0];
        end
      end else if (phase && chan_b_action_reg[1]) begin
        if (match_b_ev && (cmp_b_act_reg != top_val)) begin
          wave_b_reg <= down_reg ? !chan_b_action_reg[0] : chan_b_action_reg[0];
        end else if (upd_ev && (cmp_b_act_reg == top_val)) begin
          wave_b_reg <= !chan_b_action_reg[0];
        end
      end
    end
  end

  // pin mux; the pad drives only when the port direction says output
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_b_out            <= 1'b0;
      pin_b_oe_out         <= 1'b0;
      wave_b_connected_out <= 1'b0;
    end else if (clk_en_in) begin
      wave_b_connected_out <= |chan_b_action_reg;
      pin_b_out            <= (|chan_b_action_reg) ? wave_b_reg : port_b_data_in;
      pin_b_oe_out         <= port_b_dir_in;
    end
  end

  // read port; data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_out <= TMW_REG_RESET;
    end else if (clk_en_in) begin
      rdata_out <= TMW_REG_RESET;
      if (rd_in) begin
        unique case (addr_in)
          TMW_ADDR_CTRL_A: rdata_out <= {chan_a_action_reg, chan_b_action_reg, 2'b00, wgm_lo_reg};
          TMW_ADDR_CTRL_B: rdata_out <= {4'h0, wgm2_reg, tick_source_sel_reg};
          TMW_ADDR_COUNT:  rdata_out <= count_reg;
          TMW_ADDR_CMP_A:  rdata_out <= cmp_a_buf_reg;
          TMW_ADDR_CMP_B:  rdata_out <= cmp_b_buf_reg;
          TMW_ADDR_FLAGS:  rdata_out <= {5'h00, flags_reg};
          default:         rdata_out <= TMW_REG_RESET;
        endcase
      end
    end
  end

  assign count_out        = count_reg;
  assign wrap_flag_out    = flags_reg[TMW_FLAG_WRAP];
  assign match_a_flag_out = flags_reg[TMW_FLAG_MATCH_A];
  assign match_b_flag_out = flags_reg[TMW_FLAG_MATCH_B];

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n);

  sequence s_np_event;
    clk_en_in && !pwm && (match_b_ev || force_b);
  endsequence
  sequence s_rise_seen;
    ext_s2_reg && !ext_s3_reg;
  endsequence
  sequence s_cnt_write;
    cnt_wr && clk_en_in;
  endsequence

  chk_np_clear: assert property (s_np_event ##0 (chan_b_action_reg == TMW_ACT_CLEAR) |=> !wave_b_reg)
    else $error("non-PWM clear action did not clear the output");
  chk_np_set: assert property (s_np_event ##0 (chan_b_action_reg == TMW_ACT_SET) |=> wave_b_reg)
    else $error("non-PWM set action did not set the output");
  chk_pin_enable: assert property (clk_en_in |=> (pin_b_oe_out == $past(port_b_dir_in)) &&
                                   (wave_b_connected_out == $past(|chan_b_action_reg)))
    else $error("pin enable or connection wrong");
  chk_fast_bottom: assert property (clk_en_in && fast && (chan_b_action_reg == TMW_ACT_CLEAR) && upd_ev
                                    |=> wave_b_reg)
    else $error("fast PWM did not set at bottom");
  chk_phase_up: assert property (clk_en_in && phase && (chan_b_action_reg == TMW_ACT_CLEAR) && match_b_ev &&
                                 !down_reg && (cmp_b_act_reg != top_val) |=> !wave_b_reg)
    else $error("phase PWM up match did not clear");
  chk_phase_top: assert property (clk_en_in && phase && (chan_b_action_reg == TMW_ACT_CLEAR) && upd_ev &&
                                  (cmp_b_act_reg == top_val) |=> wave_b_reg)
    else $error("phase PWM top case did not set");
  chk_rsvd_zero: assert property (rd_in && clk_en_in && (addr_in == TMW_ADDR_CTRL_A) |=> rdata_out[3:2] == 2'b00)
    else $error("reserved bits read nonzero");
  chk_strobe_zero: assert property (rd_in && clk_en_in && (addr_in == TMW_ADDR_CTRL_B) |=> rdata_out[7:4] == 4'h0)
    else $error("force or reserved bits read nonzero");
  chk_pwm_hold: assert property (clk_en_in && pwm && !upd_ev |=> $stable(cmp_b_act_reg))
    else $error("active compare changed away from top in PWM");
  chk_wrap_max: assert property (clk_en_in && !phase && (wave_mode_sel != TMW_WM_FAST_A) && step &&
                                 (count_reg == TMW_MAX) |=> flags_reg[TMW_FLAG_WRAP])
    else $error("wrap flag missed at max");
  chk_pwm_quiet: assert property (clk_en_in && pwm && !step |=> $stable(wave_b_reg))
    else $error("output moved in PWM without a tick");
  chk_force_quiet: assert property (force_b && clk_en_in && !step && !match_b_ack_in
                                    |=> $stable(flags_reg) && $stable(count_reg))
    else $error("force strobe touched flag or counter");
  chk_block_arm: assert property (s_cnt_write |=> block_reg)
    else $error("counter write did not arm match blocking");
  chk_block_match: assert property (block_reg |-> !match_b_ev && !match_a_ev)
    else $error("match while blocked");
  chk_match_flag: assert property (clk_en_in && match_b_ev |=> flags_reg[TMW_FLAG_MATCH_B])
    else $error("match B flag not set");
  chk_stop_tick: assert property ((tick_source_sel_reg == TMW_CS_STOP) |-> !tick)
    else $error("tick while stopped");
  chk_ext_rise: assert property (s_rise_seen ##0 (tick_source_sel_reg == TMW_CS_EXT_RISE) |-> tick)
    else $error("rising pin edge gave no tick");

endmodule : tmw_top

`default_nettype wire

// ==== src/tmw_pkg.sv ====
/*
  tmw_pkg: register map, field positions, codes and masks of the 8-bit timer wave and clock control block.
  Assumes a byte-wide register port with 8-bit addresses.
*/
package tmw_pkg;

  // register addresses
  localparam logic [7:0] TMW_ADDR_FLAGS  = 8'h15;
  localparam logic [7:0] TMW_ADDR_CTRL_A = 8'h24;
  localparam logic [7:0] TMW_ADDR_CTRL_B = 8'h25;
  localparam logic [7:0] TMW_ADDR_COUNT  = 8'h26;
  localparam logic [7:0] TMW_ADDR_CMP_A  = 8'h27;
  localparam logic [7:0] TMW_ADDR_CMP_B  = 8'h28;

  localparam logic [7:0] TMW_REG_RESET   = 8'h00;
  localparam logic [7:0] TMW_MAX         = 8'hff;
  localparam logic [7:0] TMW_BOTTOM      = 8'h00;

  // field positions
  localparam int TMW_FOC_A_BIT    = 7;
  localparam int TMW_FOC_B_BIT    = 6;
  localparam int TMW_WGM2_BIT     = 3;
  localparam int TMW_ACT_A_LSB    = 6;
  localparam int TMW_ACT_B_LSB    = 4;
  localparam int TMW_CS_LSB       = 0;
  localparam int TMW_WGM_LO_LSB   = 0;
  localparam int TMW_FLAG_WRAP    = 0;
  localparam int TMW_FLAG_MATCH_A = 1;
  localparam int TMW_FLAG_MATCH_B = 2;

  // output action codes
  localparam logic [1:0] TMW_ACT_OFF    = 2'h0;
  localparam logic [1:0] TMW_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TMW_ACT_CLEAR  = 2'h2;
  localparam logic [1:0] TMW_ACT_SET    = 2'h3;

  // wave modes
  localparam logic [2:0] TMW_WM_NORMAL  = 3'h0;
  localparam logic [2:0] TMW_WM_PHASE   = 3'h1;
  localparam logic [2:0] TMW_WM_CTC     = 3'h2;
  localparam logic [2:0] TMW_WM_FAST    = 3'h3;
  localparam logic [2:0] TMW_WM_RSVD4   = 3'h4;
  localparam logic [2:0] TMW_WM_PHASE_A = 3'h5;
  localparam logic [2:0] TMW_WM_RSVD6   = 3'h6;
  localparam logic [2:0] TMW_WM_FAST_A  = 3'h7;

  // tick sources
  localparam logic [2:0] TMW_CS_STOP     = 3'h0;
  localparam logic [2:0] TMW_CS_DIV1     = 3'h1;
  localparam logic [2:0] TMW_CS_DIV8     = 3'h2;
  localparam logic [2:0] TMW_CS_DIV64    = 3'h3;
  localparam logic [2:0] TMW_CS_DIV256   = 3'h4;
  localparam logic [2:0] TMW_CS_DIV1024  = 3'h5;
  localparam logic [2:0] TMW_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TMW_CS_EXT_RISE = 3'h7;

  // prescaler terminal masks
  localparam logic [9:0] TMW_MASK_DIV8    = 10'h007;
  localparam logic [9:0] TMW_MASK_DIV64   = 10'h03f;
  localparam logic [9:0] TMW_MASK_DIV256  = 10'h0ff;
  localparam logic [9:0] TMW_MASK_DIV1024 = 10'h3ff;

endpackage : tmw_pkg

// ==== tb/tb.sv ====
/*
  tb: self-checking bench for tmw_top covering the register port, channel-B force strobe, tick sources, flags and PWM pin.
  Assumes tmw_pkg is compiled first; the design carries its own assertions, so there is no separate checker.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  import tmw_pkg::*;
  logic       ref_clk_in       = 1'b0;
  logic       resetn_in        = 1'b0;
  logic       clk_en_in        = 1'b1;
  logic [7:0] addr_in          = 8'h00;
  logic [7:0] wdata_in         = 8'h00;
  logic       wr_in            = 1'b0;
  logic       rd_in            = 1'b0;
  logic       ext_count_pin_in = 1'b0;
  logic       port_b_dir_in    = 1'b1;
  logic       port_b_data_in   = 1'b0;
  logic       match_b_ack_in   = 1'b0;
  logic       smp              = 1'b0;
  logic       rd_seen          = 1'b0;
  logic       pin_seen         = 1'b0;
  logic [7:0] rdata_out, count_out, got, v;
  logic       pin_b_out, pin_b_oe_out, wave_b_connected_out, wrap_flag_out, match_a_flag_out, match_b_flag_out;
  logic [7:0] exp_q[$];
  string      name_q[$];
  logic [7:0] regs [6]   = '{TMW_ADDR_FLAGS, TMW_ADDR_CTRL_A, TMW_ADDR_CTRL_B, TMW_ADDR_COUNT, TMW_ADDR_CMP_A, TMW_ADDR_CMP_B};
  logic [1:0] acts [4]   = '{2'h3, 2'h1, 2'h1, 2'h2};
  logic       pins [4]   = '{1'b1, 1'b0, 1'b1, 1'b0};
  int         divs [5]   = '{1, 8, 64, 256, 1024};
  int         num_errors = 0;
  int         comparisons = 0;
  int         cycles     = 0;
  int         seed       = 9;

  tmw_top tmw_top_inst (.ref_clk_in, .resetn_in, .clk_en_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .ext_count_pin_in, .port_b_dir_in, .port_b_data_in, .match_b_ack_in, .pin_b_out, .pin_b_oe_out,
    .wave_b_connected_out, .count_out, .wrap_flag_out, .match_a_flag_out, .match_b_flag_out);

  always #4 ref_clk_in = ~ref_clk_in;

  task automatic finish_test;
    if (num_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    wr_in    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    exp_q.push_back(e);
    name_q.push_back(n);
    @(posedge ref_clk_in);
    rd_in   <= 1'b0;
  endtask : rd

  // sampled as {connected, drive enable, pad value}
  task automatic pin(input logic [2:0] e);
    @(posedge ref_clk_in);
    smp <= 1'b1;
    exp_q.push_back({5'h00, e});
    name_q.push_back("pin b");
    @(posedge ref_clk_in);
    smp <= 1'b0;
  endtask : pin

  // the stop write lands a fixed two edges after the wait, so w + 2 undivided ticks elapse
  task automatic run(input logic [2:0] cs, input int w);
    wr(TMW_ADDR_CTRL_B, {5'h00, cs});
    repeat (w) @(posedge ref_clk_in);
    wr(TMW_ADDR_CTRL_B, 8'h00);
  endtask : run

  always @(posedge ref_clk_in) begin
    rd_seen  <= rd_in;
    pin_seen <= smp;
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      finish_test();
    end
  end

  // read data stand only in the cycle after the strobe, so look mid-cycle
  always @(negedge ref_clk_in) begin
    if ((rd_seen || pin_seen) && exp_q.size() > 0) begin
      got = rd_seen ? rdata_out : {5'h00, wave_b_connected_out, pin_b_oe_out, pin_b_out};
      comparisons++;
      if (got !== exp_q[0]) begin
        num_errors++;
        $display("mismatch %s expected %h seen %h", name_q[0], exp_q[0], got);
      end
      void'(exp_q.pop_front());
      void'(name_q.pop_front());
    end
  end

  initial begin
    repeat (12) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    for (int i = 0; i < 6; i++) begin
      rd(regs[i], TMW_REG_RESET, "reset value");
    end
    repeat (4) begin
      v = 8'($random(seed));
      wr(TMW_ADDR_CTRL_A, v);
      rd(TMW_ADDR_CTRL_A, v & 8'hf3, "ctrl_a");
      wr(TMW_ADDR_CTRL_B, v & 8'h38);
      rd(TMW_ADDR_CTRL_B, v & 8'h08, "ctrl_b");
    end
    wr(8'h30, 8'h5a);
    rd(8'h30, 8'h00, "unmapped");
    wr(TMW_ADDR_COUNT, 8'h33);
    for (int i = 0; i < 4; i++) begin
      wr(TMW_ADDR_CTRL_A, {2'h0, acts[i], 4'h2});
      wr(TMW_ADDR_CTRL_B, 8'h40);
      pin({2'b11, pins[i]});
    end
    rd(TMW_ADDR_CTRL_B, 8'h00, "force bits");
    rd(TMW_ADDR_FLAGS, 8'h00, "flags after force");
    rd(TMW_ADDR_COUNT, 8'h33, "count after force");
    @(posedge ref_clk_in);
    port_b_dir_in <= 1'b0;
    pin(3'b100);
    wr(TMW_ADDR_CTRL_A, 8'h00);
    port_b_data_in <= 1'b1;
    pin(3'b001);
    port_b_dir_in  <= 1'b1;
    port_b_data_in <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      wr(TMW_ADDR_COUNT, 8'h00);
      run(3'(i + 1), 5 * divs[i] + divs[i] / 2 - 2);
      rd(TMW_ADDR_COUNT, 8'h05, "prescaled count");
    end
    for (int s = 6; s < 8; s++) begin
      wr(TMW_ADDR_COUNT, 8'h00);
      wr(TMW_ADDR_CTRL_B, 8'(s));
      repeat ((s == 6) ? 5 : 3) begin
        repeat (5) @(posedge ref_clk_in);
        ext_count_pin_in <= ~ext_count_pin_in;
      end
      repeat (6) @(posedge ref_clk_in);
      wr(TMW_ADDR_CTRL_B, 8'h00);
      rd(TMW_ADDR_COUNT, (s == 6) ? 8'h02 : 8'h01, "pin edge count");
    end
    wr(TMW_ADDR_FLAGS, 8'h07);
    wr(TMW_ADDR_CMP_B, 8'h04);
    wr(TMW_ADDR_COUNT, 8'h04);
    run(3'h1, 3);
    rd(TMW_ADDR_FLAGS, 8'h00, "blocked match");
    wr(TMW_ADDR_COUNT, 8'h02);
    run(3'h1, 3);
    rd(TMW_ADDR_FLAGS, 8'h04, "match b flag");
    @(posedge ref_clk_in);
    match_b_ack_in <= 1'b1;
    @(posedge ref_clk_in);
    match_b_ack_in <= 1'b0;
    rd(TMW_ADDR_FLAGS, 8'h00, "flag after vector");
    wr(TMW_ADDR_CMP_B, 8'h10);
    wr(TMW_ADDR_COUNT, 8'hfd);
    run(3'h1, 3);
    rd(TMW_ADDR_FLAGS, 8'h03, "wrap flag");
    wr(TMW_ADDR_FLAGS, 8'h01);
    rd(TMW_ADDR_FLAGS, 8'h02, "flag written one");
    wr(TMW_ADDR_CMP_B, 8'h80);
    for (int k = 2; k < 4; k++) begin
      wr(TMW_ADDR_CTRL_A, {2'h0, 2'(5 - k), 4'h0});
      wr(TMW_ADDR_CTRL_B, 8'h40);
      wr(TMW_ADDR_CTRL_A, {2'h0, 2'(k), 4'h3});
      wr(TMW_ADDR_COUNT, 8'h70);
      run(3'h1, 30);
      pin({2'b11, k == 3});
      wr(TMW_ADDR_COUNT, 8'hf0);
      run(3'h1, 30);
      pin({2'b11, k == 2});
    end
    // phase-correct mode 1: clear on the way up, set on the way down, wrap at bottom
    wr(TMW_ADDR_CTRL_A, 8'h30);
    wr(TMW_ADDR_CTRL_B, 8'h40);
    wr(TMW_ADDR_CTRL_A, 8'h21);
    wr(TMW_ADDR_COUNT, 8'h70);
    run(3'h1, 30);
    pin(3'b110);
    wr(TMW_ADDR_COUNT, 8'hf0);
    run(3'h1, 150);
    pin(3'b111);
    wr(TMW_ADDR_FLAGS, 8'h07);
    wr(TMW_ADDR_COUNT, 8'h03);
    run(3'h1, 3);
    rd(TMW_ADDR_FLAGS, 8'h03, "phase wrap flag");
    repeat (4) @(posedge ref_clk_in);
    finish_test();
  end
endmodule : tb
`default_nettype wire
